/* logic/afio_pkg.sv */
// shared constants and helpers for the axis feedback and i/o unit
`default_nettype none
package afio_pkg;
	localparam int CLK_HZ = 40_000_000;
	localparam int N_AXES = 4;
	localparam int N_ENC = 6;
	localparam int AUX1_IDX = 4;
	localparam int AUX2_IDX = 5;
	localparam int POS_W = 32;
	// sample period of velocity and timer interrupt
	localparam int TICK_PERIOD_US = 1000;
	localparam int TICK_CYCLES_DEF = TICK_PERIOD_US * (CLK_HZ / 1_000_000);
	localparam int TICK_CNT_W = 16;
	// register byte offsets
	localparam logic [7:0] OFS_ENC_DIR = 8'h00;
	localparam logic [7:0] OFS_GP_IN = 8'h04;
	localparam logic [7:0] OFS_GP_OUT = 8'h08;
	localparam logic [7:0] OFS_AUX_SEL = 8'h0c;
	localparam logic [7:0] OFS_AUX_POS = 8'h10;
	localparam logic [7:0] OFS_AUX_VEL = 8'h14;
	localparam logic [7:0] OFS_BRK_ARM = 8'h18;
	localparam logic [7:0] OFS_AUTO_COMMIT = 8'h1c;
	localparam logic [7:0] OFS_IRQ_SRC = 8'h20;
	localparam logic [7:0] OFS_INT_STS = 8'h24;
	localparam logic [7:0] OFS_INT_MASK = 8'h28;
	localparam logic [3:0] OFS_AXIS_STS_PAGE = 4'h3;
	// fields and reset values
	localparam int ENC_DIR_W = 6;
	localparam logic [5:0] ENC_DIR_RST = 6'h00;
	localparam logic [15:0] GPO_RST = 16'h0000;
	localparam logic [1:0] AUX_SEL_NO1 = 2'h1;
	localparam logic [1:0] AUX_SEL_NO2 = 2'h2;
	localparam int STS_EVT_W = 8;
	localparam int STS_BRK_BIT = 2;
	localparam int INT_W = 5;
	localparam int INT_TICK_BIT = 4;
	localparam logic [4:0] INT_EVENT_SRC = 5'h0f;
	localparam logic [4:0] INT_TIMER_SRC = 5'h10;
	localparam logic IRQ_SRC_TIMER = 1'b0;
	localparam logic IRQ_SRC_EVENT = 1'b1;

	typedef enum logic [1:0] {
		BRK_IDLE = 2'b01,
		BRK_ARMED = 2'b10
	} afio_brk_state_t;

	// byte-lane merge of a wishbone write
	function automatic logic [31:0] wb_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] sel);
		logic [31:0] r;
		r = old_v;
		for (int k = 0; k < 4; k++)
		begin
			if (sel[k])
				r[8*k +: 8] = new_v[8*k +: 8];
		end
		return r;
	endfunction
endpackage
`default_nettype wire

/* logic/afio_enc_if.sv */
// link between an encoder counter and its owner
`default_nettype none
interface afio_enc_if;
	logic reverse;
	logic [31:0] pos;
	modport counter (input reverse, output pos);
	modport owner (output reverse, input pos);
endinterface
`default_nettype wire

/* logic/afio_quad_counter.sv */
// quadrature position counter with direction reversal
`default_nettype none
module afio_quad_counter
	import afio_pkg::*;
(
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic nrst_in,
	// encoder phases
	input wire logic enc_a_in,
	input wire logic enc_b_in,
	// owner side
	afio_enc_if.counter enc_io
);
	logic a_reg;
	logic b_reg;
	logic [POS_W-1:0] pos_reg;
	logic [POS_W-1:0] pos_next;
	wire logic step = (enc_a_in ^ a_reg) ^ (enc_b_in ^ b_reg);
	// reversal flips only new steps, never the stored count
	wire logic up = (enc_a_in ^ b_reg) ^ enc_io.reverse; // [RQ3] [RQ15]

	assign pos_next = !step ? pos_reg :
		(up ? pos_reg + 32'h1 : pos_reg - 32'h1);
	assign enc_io.pos = pos_reg;

	always_ff @(posedge sys_clk_in)
	begin
		if (!nrst_in)
		begin
			a_reg <= 1'b0;
			b_reg <= 1'b0;
			pos_reg <= '0;
		end
		else
		begin
			a_reg <= enc_a_in;
			b_reg <= enc_b_in;
			pos_reg <= pos_next;
		end
	end

	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!nrst_in);

	AST_REV_COUNT: assert property (step && (enc_a_in ^ b_reg) && // [RQ3]
		enc_io.reverse |=> pos_reg == $past(pos_reg) - 32'h1)
		else $error("reversed encoder did not count down");
	AST_FWD_COUNT: assert property (step && (enc_a_in ^ b_reg) && // [RQ3]
		!enc_io.reverse |=> pos_reg == $past(pos_reg) + 32'h1)
		else $error("plain encoder did not count up");
	AST_REV_KEEPS_POS: assert property (!step && // [RQ15]
		$changed(enc_io.reverse) |=> $stable(pos_reg))
		else $error("reversal change altered position");
endmodule // afio_quad_counter
`default_nettype wire

/* logic/afio_home_brk.sv */
// one-shot home switch breakpoint of one axis
`default_nettype none
module afio_home_brk
	import afio_pkg::*;
(
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic nrst_in,
	// control
	input wire logic arm_in,
	input wire logic home_in,
	// state and trigger
	output logic armed_out,
	output logic hit_out
);
	afio_brk_state_t state_reg;
	afio_brk_state_t state_next;

	assign armed_out = state_reg == BRK_ARMED;
	assign hit_out = armed_out & home_in; // [RQ8]

	// a fresh arm in the trigger cycle keeps the breakpoint armed
	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			BRK_IDLE:
				if (arm_in)
					state_next = BRK_ARMED;
			BRK_ARMED:
				if (home_in && !arm_in)
					state_next = BRK_IDLE; // [RQ9]
			default:
				state_next = BRK_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk_in)
	begin
		if (!nrst_in)
			state_reg <= BRK_IDLE;
		else
			state_reg <= state_next;
	end

	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!nrst_in);

	sequence s_trigger;
		armed_out && home_in && !arm_in;
	endsequence
	sequence s_quiet;
		!arm_in [*2];
	endsequence

	AST_DISARM: assert property (s_trigger ##1 s_quiet |-> // [RQ9]
		!hit_out && !$past(hit_out, 1) || $past(arm_in))
		else $error("breakpoint fired again without arming");
	AST_IDLE_NO_HIT: assert property (!armed_out |-> !hit_out) // [RQ8]
		else $error("breakpoint hit while not armed");
	AST_ARM_TAKES: assert property (arm_in && !armed_out |=> armed_out)
		else $error("arm request not taken");
endmodule // afio_home_brk
`default_nettype wire

/* logic/afio_unit.sv */
// axis feedback and general i/o unit with wishbone register slave
// Summary of operation
// [RQ1] Two auxiliary counters; selected counter's position is read by host.
// [RQ2] Velocity of the selected auxiliary counter is measured and readable.
// [RQ3] Reversal bit one inverts an encoder's counting; zero leaves it alone.
// [RQ4] Bits 0-3 axes, 4 and 5 auxiliaries; bits 6-15 unused, zero.
// [RQ5] All reversal bits are zero after reset.
// [RQ6] Sixteen general input lines read as one word, bit n is line n.
// [RQ7] Written word drives general output line n from bit n.
// [RQ8] Armed home breakpoint sets axis breakpoint flag when home is active.
// [RQ9] A triggered breakpoint disarms until the host arms it again.
// [RQ10] Trigger with auto-commit set commits the axis's buffered parameters.
// [RQ11] Event mode takes the interrupt from axis events, not the timer.
// [RQ12] Breakpoint flag sits in bit 2 of each axis status word.
// [RQ13] Event flags 0-7 clear on command and set again on next event.
// [RQ14] General outputs are zero after reset until the host writes them.
// [RQ15] Reversal change affects later counts only, not the stored position.
`default_nettype none
module afio_unit
	import afio_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYCLES_DEF
)
(
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic nrst_in,
	// wishbone slave
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [7:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out,
	// encoders, axes 0-3 then auxiliaries
	input wire logic [N_ENC-1:0] enc_a_in,
	input wire logic [N_ENC-1:0] enc_b_in,
	// axis switches and events
	input wire logic [N_AXES-1:0] home_in,
	input wire logic [N_AXES*STS_EVT_W-1:0] axis_event_in,
	// general purpose lines
	input wire logic [15:0] general_input_line_in,
	output logic [15:0] general_output_line_out,
	// commit and interrupt
	output logic [N_AXES-1:0] axis_commit_out,
	output logic irq_out
);
	logic ack_reg;
	logic [31:0] dat_reg;
	logic [ENC_DIR_W-1:0] enc_dir_reg;
	logic [15:0] gpo_reg;
	logic [1:0] aux_sel_reg;
	logic [N_AXES-1:0] auto_commit_reg;
	logic irq_src_reg;
	logic [INT_W-1:0] int_sts_reg;
	logic [INT_W-1:0] int_sts_next;
	logic [INT_W-1:0] int_mask_reg;
	logic [N_AXES-1:0] commit_reg;
	logic [STS_EVT_W-1:0] axis_evt_reg [N_AXES];
	logic [POS_W-1:0] last_pos_reg [2];
	logic [POS_W-1:0] vel_reg [2];
	logic [TICK_CNT_W-1:0] tick_cnt_reg;
	logic [N_AXES-1:0] brk_armed;
	logic [N_AXES-1:0] brk_hit;
	logic [N_AXES-1:0] axis_any;
	logic [31:0] rd_mux;

	afio_enc_if enc_if [N_ENC] ();

	// bus decode
	wire logic req = wb_cyc_in & wb_stb_in;
	wire logic rd_take = req & ~ack_reg;
	wire logic wr_fire = req & wb_we_in & ack_reg;
	wire logic hit_dir = wb_adr_in == OFS_ENC_DIR;
	wire logic hit_gpi = wb_adr_in == OFS_GP_IN;
	wire logic hit_gpo = wb_adr_in == OFS_GP_OUT;
	wire logic hit_auxsel = wb_adr_in == OFS_AUX_SEL;
	wire logic hit_auxpos = wb_adr_in == OFS_AUX_POS;
	wire logic hit_auxvel = wb_adr_in == OFS_AUX_VEL;
	wire logic hit_arm = wb_adr_in == OFS_BRK_ARM;
	wire logic hit_auto = wb_adr_in == OFS_AUTO_COMMIT;
	wire logic hit_src = wb_adr_in == OFS_IRQ_SRC;
	wire logic hit_ists = wb_adr_in == OFS_INT_STS;
	wire logic hit_imask = wb_adr_in == OFS_INT_MASK;
	wire logic hit_axsts = wb_adr_in[7:4] == OFS_AXIS_STS_PAGE;
	wire logic [1:0] ax_idx = wb_adr_in[3:2];
	wire logic [31:0] wr_word = wb_merge(32'h0, wb_dat_in, wb_sel_in);
	wire logic [31:0] dir_merged = wb_merge({26'h0, enc_dir_reg}, wb_dat_in,
		wb_sel_in);
	wire logic [31:0] gpo_merged = wb_merge({16'h0, gpo_reg}, wb_dat_in,
		wb_sel_in);
	wire logic aux_is2 = aux_sel_reg == AUX_SEL_NO2;
	wire logic tick = tick_cnt_reg == TICK_CNT_W'(TICK_CYCLES - 1);
	wire logic [31:0] aux_pos [2];
	wire logic [INT_W-1:0] src_gate =
		irq_src_reg == IRQ_SRC_EVENT ? INT_EVENT_SRC : INT_TIMER_SRC;

	assign aux_pos[0] = enc_if[AUX1_IDX].pos; // [RQ1]
	assign aux_pos[1] = enc_if[AUX2_IDX].pos;

	genvar g;
	generate
		for (g = 0; g < N_ENC; g++)
		begin : g_enc
			assign enc_if[g].reverse = enc_dir_reg[g]; // [RQ4]
			afio_quad_counter u_cnt (
				.sys_clk_in(sys_clk_in),
				.nrst_in(nrst_in),
				.enc_a_in(enc_a_in[g]),
				.enc_b_in(enc_b_in[g]),
				.enc_io(enc_if[g].counter)
			);
		end
		for (g = 0; g < N_AXES; g++)
		begin : g_axis
			afio_home_brk u_brk (
				.sys_clk_in(sys_clk_in),
				.nrst_in(nrst_in),
				.arm_in(wr_fire & hit_arm & wr_word[g]),
				.home_in(home_in[g]),
				.armed_out(brk_armed[g]),
				.hit_out(brk_hit[g])
			);
			assign axis_any[g] = |axis_event_in[g*STS_EVT_W +: STS_EVT_W]
				| brk_hit[g];
			always_ff @(posedge sys_clk_in)
			begin
				if (!nrst_in)
					axis_evt_reg[g] <= '0;
				else
					axis_evt_reg[g] <= (axis_evt_reg[g] &
						~((wr_fire && hit_axsts && ax_idx == 2'(g)) ?
						wr_word[STS_EVT_W-1:0] : 8'h00)) | // [RQ13]
						axis_event_in[g*STS_EVT_W +: STS_EVT_W] |
						(8'(brk_hit[g]) << STS_BRK_BIT); // [RQ12]
			end
		end
	endgenerate

	// read data: unmapped and write-only addresses read zero
	always_comb
	begin
		rd_mux = 32'h0;
		if (hit_dir)
			rd_mux = {26'h0, enc_dir_reg}; // [RQ4]
		else if (hit_gpi)
			rd_mux = {16'h0, general_input_line_in}; // [RQ6]
		else if (hit_auxsel)
			rd_mux = {30'h0, aux_sel_reg};
		else if (hit_auxpos)
			rd_mux = aux_pos[aux_is2]; // [RQ1]
		else if (hit_auxvel)
			rd_mux = vel_reg[aux_is2]; // [RQ2]
		else if (hit_arm)
			rd_mux = {28'h0, brk_armed};
		else if (hit_auto)
			rd_mux = {28'h0, auto_commit_reg};
		else if (hit_src)
			rd_mux = {31'h0, irq_src_reg};
		else if (hit_ists)
			rd_mux = {27'h0, int_sts_reg};
		else if (hit_imask)
			rd_mux = {27'h0, int_mask_reg};
		else if (hit_axsts)
			rd_mux = {18'h0, ax_idx, 4'h0, axis_evt_reg[ax_idx]};
	end

	always_ff @(posedge sys_clk_in)
	begin
		if (!nrst_in)
		begin
			ack_reg <= 1'b0;
			dat_reg <= 32'h0;
		end
		else
		begin
			ack_reg <= rd_take;
			if (rd_take)
				dat_reg <= rd_mux;
		end
	end

	assign wb_ack_out = ack_reg;
	assign wb_dat_out = dat_reg;

	// software-written control
	always_ff @(posedge sys_clk_in)
	begin
		if (!nrst_in)
		begin
			enc_dir_reg <= ENC_DIR_RST; // [RQ5]
			gpo_reg <= GPO_RST; // [RQ14]
			aux_sel_reg <= AUX_SEL_NO1;
			auto_commit_reg <= '0;
			irq_src_reg <= IRQ_SRC_TIMER;
			int_mask_reg <= '0;
		end
		else if (wr_fire)
		begin
			if (hit_dir)
				enc_dir_reg <= dir_merged[ENC_DIR_W-1:0]; // [RQ3] [RQ4]
			if (hit_gpo)
				gpo_reg <= gpo_merged[15:0]; // [RQ7]
			if (hit_auxsel && (wb_sel_in[0]) &&
				(wb_dat_in[1:0] == AUX_SEL_NO1 ||
				wb_dat_in[1:0] == AUX_SEL_NO2))
				aux_sel_reg <= wb_dat_in[1:0];
			if (hit_auto && wb_sel_in[0])
				auto_commit_reg <= wb_dat_in[N_AXES-1:0];
			if (hit_src && wb_sel_in[0])
				irq_src_reg <= wb_dat_in[0]; // [RQ11]
			if (hit_imask && wb_sel_in[0])
				int_mask_reg <= wb_dat_in[INT_W-1:0];
		end
	end

	assign general_output_line_out = gpo_reg;

	// sticky interrupt status, a new event beats a clear
	assign int_sts_next = (int_sts_reg & ~((wr_fire && hit_ists) ?
		wr_word[INT_W-1:0] : 5'h00)) | {tick, axis_any};

	// sample clock, commit pulses and velocity
	always_ff @(posedge sys_clk_in)
	begin
		if (!nrst_in)
		begin
			tick_cnt_reg <= '0;
			int_sts_reg <= '0;
			commit_reg <= '0;
			last_pos_reg <= '{default: '0};
			vel_reg <= '{default: '0};
		end
		else
		begin
			tick_cnt_reg <= tick ? '0 : tick_cnt_reg + 16'h1;
			int_sts_reg <= int_sts_next;
			commit_reg <= brk_hit & auto_commit_reg; // [RQ10]
			if (tick)
			begin
				for (int k = 0; k < 2; k++)
				begin
					vel_reg[k] <= aux_pos[k] - last_pos_reg[k]; // [RQ2]
					last_pos_reg[k] <= aux_pos[k];
				end
			end
		end
	end

	assign axis_commit_out = commit_reg;
	assign irq_out = |(int_sts_reg & int_mask_reg & src_gate); // [RQ11]

	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!nrst_in);

	sequence s_ack_pulse;
		wb_ack_out ##1 !wb_ack_out;
	endsequence

	AST_ACK_ONE_CYCLE: assert property (rd_take |=> s_ack_pulse)
		else $error("ack not a single cycle pulse");
	AST_DIR_RESET: assert property ($rose(nrst_in) |-> // [RQ5]
		enc_dir_reg == ENC_DIR_RST && general_output_line_out == GPO_RST)
		else $error("reversal or outputs not cleared by reset");
	AST_GPI_READ: assert property (rd_take && hit_gpi |=> // [RQ6]
		wb_dat_out == {16'h0, $past(general_input_line_in)})
		else $error("general inputs misread");
	AST_GPO_WRITE: assert property (wr_fire && hit_gpo && // [RQ7]
		wb_sel_in == 4'hf |=> general_output_line_out ==
		$past(wb_dat_in[15:0]))
		else $error("general outputs not updated");
	AST_AUX_POS: assert property (rd_take && hit_auxpos && // [RQ1]
		aux_sel_reg == AUX_SEL_NO2 |=> wb_dat_out == $past(aux_pos[1]))
		else $error("aux position of counter two misread");

	// breakpoint flag, commit and event-mode interrupt
	AST_BRK_FLAG: assert property (brk_hit[1] |=> // [RQ8] [RQ12]
		axis_evt_reg[1][STS_BRK_BIT] && int_sts_reg[1])
		else $error("breakpoint flag not set");
	AST_HIT_DISARMS: assert property (brk_hit[1] && // [RQ9]
		!(wr_fire && hit_arm && wr_word[1]) |=> !brk_armed[1])
		else $error("breakpoint still armed after trigger");
	AST_COMMIT: assert property (brk_hit[1] && auto_commit_reg[1] |=> // [RQ10]
		axis_commit_out[1] ##1 !axis_commit_out[1] || brk_hit[1])
		else $error("commit pulse missing");
	AST_NO_COMMIT: assert property (!brk_hit[2] |=> // [RQ10]
		!axis_commit_out[2])
		else $error("commit without trigger");
	AST_EVENT_ONLY: assert property (irq_src_reg == IRQ_SRC_EVENT && // [RQ11]
		(int_sts_reg & int_mask_reg & INT_EVENT_SRC) == 5'h00 |-> !irq_out)
		else $error("timer raised irq in event mode");
	AST_EVT_CLEAR: assert property (wr_fire && hit_axsts && // [RQ13]
		ax_idx == 2'h1 && wb_sel_in[0] && wb_dat_in[STS_BRK_BIT] &&
		!axis_event_in[STS_EVT_W + STS_BRK_BIT] && !brk_hit[1] |=>
		!axis_evt_reg[1][STS_BRK_BIT])
		else $error("event flags not cleared");

	// register access and write effects
	AST_NO_ACK_IDLE: assert property (!req |=> !wb_ack_out)
		else $error("ack without a request");
	AST_DIR_WRITE: assert property (wr_fire && hit_dir && // [RQ3] [RQ4]
		wb_sel_in[0] |=> enc_dir_reg == $past(wb_dat_in[ENC_DIR_W-1:0]))
		else $error("reversal bits not written");
	AST_DIR_UNUSED: assert property (rd_take && hit_dir |=> // [RQ4]
		wb_dat_out[31:ENC_DIR_W] == '0)
		else $error("unused reversal bits read nonzero");
	AST_GPO_HOLD: assert property (!(wr_fire && hit_gpo) |=> // [RQ14]
		$stable(general_output_line_out))
		else $error("general outputs moved without a write");
	AST_AUX_SEL_KEEP: assert property (wr_fire && hit_auxsel &&
		wb_dat_in[1:0] != AUX_SEL_NO1 && wb_dat_in[1:0] != AUX_SEL_NO2
		|=> $stable(aux_sel_reg))
		else $error("aux select took an illegal number");

	// auxiliary position and velocity
	AST_AUX_POS1: assert property (rd_take && hit_auxpos && // [RQ1]
		!aux_is2 |=> wb_dat_out == $past(aux_pos[0]))
		else $error("aux position of counter one misread");
	AST_VEL_SAMPLE: assert property (tick |=> vel_reg[0] == // [RQ2]
		$past(aux_pos[0]) - $past(last_pos_reg[0]))
		else $error("velocity not sampled over the window");
	AST_VEL_READ: assert property (rd_take && hit_auxvel && // [RQ2]
		!aux_is2 |=> wb_dat_out == $past(vel_reg[0]))
		else $error("aux velocity misread");

	// event flags and interrupt source
	AST_EVT_SET: assert property (axis_event_in[7:0] != 8'h00 |=> // [RQ13]
		(axis_evt_reg[0] & $past(axis_event_in[7:0])) ==
		$past(axis_event_in[7:0]))
		else $error("axis event flag not set");
	AST_STS_SET_WINS: assert property (axis_any[0] |=> // [RQ13]
		int_sts_reg[0])
		else $error("event lost against a clear");
	AST_TICK_STS: assert property (tick |=> // [RQ11]
		int_sts_reg[INT_TICK_BIT])
		else $error("tick did not set its status bit");
	AST_TIMER_ONLY: assert property (irq_src_reg == IRQ_SRC_TIMER && // [RQ11]
		!(int_sts_reg[INT_TICK_BIT] && int_mask_reg[INT_TICK_BIT])
		|-> !irq_out)
		else $error("axis event raised irq in timer mode");
	AST_IRQ_MASKED: assert property (int_mask_reg == '0 |-> // [RQ11]
		!irq_out)
		else $error("masked status raised irq");
endmodule // afio_unit
`default_nettype wire

/* tb/testbench.sv */
// self-checking bench for the axis feedback and i/o unit
`default_nettype none
module testbench
	import afio_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic sys_clk_in;
	logic nrst_in;
	logic wb_cyc_in;
	logic wb_stb_in;
	logic wb_we_in;
	logic [7:0] wb_adr_in;
	logic [3:0] wb_sel_in;
	logic [31:0] wb_dat_in;
	logic [31:0] wb_dat_out;
	logic wb_ack_out;
	logic [N_ENC-1:0] enc_a_in;
	logic [N_ENC-1:0] enc_b_in;
	logic [N_AXES-1:0] home_in;
	logic [N_AXES*STS_EVT_W-1:0] axis_event_in;
	logic [15:0] general_input_line_in;
	logic [15:0] general_output_line_out;
	logic [N_AXES-1:0] axis_commit_out;
	logic irq_out;
	logic [3:0] seen;
	int n_fail;
	int n_checks;

	afio_unit #(
		.TICK_CYCLES(16)
	) u_afio_unit (
		.sys_clk_in(sys_clk_in),
		.nrst_in(nrst_in),
		.wb_cyc_in(wb_cyc_in),
		.wb_stb_in(wb_stb_in),
		.wb_we_in(wb_we_in),
		.wb_adr_in(wb_adr_in),
		.wb_sel_in(wb_sel_in),
		.wb_dat_in(wb_dat_in),
		.wb_dat_out(wb_dat_out),
		.wb_ack_out(wb_ack_out),
		.enc_a_in(enc_a_in),
		.enc_b_in(enc_b_in),
		.home_in(home_in),
		.axis_event_in(axis_event_in),
		.general_input_line_in(general_input_line_in),
		.general_output_line_out(general_output_line_out),
		.axis_commit_out(axis_commit_out),
		.irq_out(irq_out)
	);

	initial
	begin
		sys_clk_in = 1'b0;
		forever #12.5 sys_clk_in = ~sys_clk_in;
	end

	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one classic wishbone cycle, held until ack is sampled at an edge
	task automatic wb(input logic we, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		int t;
		@(posedge sys_clk_in);
		wb_cyc_in <= 1'b1;
		wb_stb_in <= 1'b1;
		wb_we_in <= we;
		wb_adr_in <= a;
		wb_sel_in <= 4'hf;
		wb_dat_in <= d;
		t = 0;
		do
		begin
			@(posedge sys_clk_in);
			t++;
		end
		while (wb_ack_out !== 1'b1 && t < 40);
		chk({31'h0, wb_ack_out}, 32'h1);
		r = wb_dat_out;
		wb_cyc_in <= 1'b0;
		wb_stb_in <= 1'b0;
		wb_we_in <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		wb(1'b1, a, d, r);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		logic [31:0] r;
		wb(1'b0, a, 32'h0, r);
		chk(r & m, e);
	endtask

	// forward quadrature steps, one phase change per cycle
	task automatic quad(input int i, input int n);
		logic [N_ENC-1:0] m;
		m = N_ENC'(1) << i;
		repeat (n)
		begin
			@(posedge sys_clk_in);
			if ((enc_a_in & m) == (enc_b_in & m))
				enc_a_in <= enc_a_in ^ m;
			else
				enc_b_in <= enc_b_in ^ m;
		end
	endtask

	task automatic irq_is(input logic e);
		@(negedge sys_clk_in);
		chk({31'h0, irq_out}, {31'h0, e});
	endtask

	task automatic wait_irq();
		int t;
		t = 0;
		do
		begin
			@(negedge sys_clk_in);
			t++;
		end
		while (irq_out !== 1'b1 && t < 64);
		chk({31'h0, irq_out}, 32'h1);
	endtask

	// home pulse on axis 1, collects commit pulses
	task automatic home_pulse();
		@(posedge sys_clk_in);
		home_in <= 4'h2;
		seen = 4'h0;
		repeat (8)
		begin
			@(negedge sys_clk_in);
			seen = seen | axis_commit_out;
		end
		@(posedge sys_clk_in);
		home_in <= 4'h0;
	endtask

	initial
	begin
		repeat (20000) @(posedge sys_clk_in);
		n_fail++;
		finish_test();
	end

	initial
	begin
		n_fail = 0;
		n_checks = 0;
		nrst_in = 1'b0;
		wb_cyc_in = 1'b0;
		wb_stb_in = 1'b0;
		wb_we_in = 1'b0;
		wb_adr_in = 8'h00;
		wb_sel_in = 4'hf;
		wb_dat_in = 32'h0;
		enc_a_in = '0;
		enc_b_in = '0;
		home_in = 4'h0;
		axis_event_in = '0;
		general_input_line_in = 16'ha5c3;
		repeat (16) @(posedge sys_clk_in);
		nrst_in <= 1'b1;
		rd(OFS_ENC_DIR, 32'hffff, 32'h0);
		chk({16'h0, general_output_line_out}, 32'h0);
		rd(OFS_GP_IN, 32'hffff, 32'ha5c3);
		wr(OFS_GP_OUT, 32'h8001);
		@(negedge sys_clk_in);
		chk({16'h0, general_output_line_out}, 32'h8001);
		rd(OFS_GP_OUT, 32'hffffffff, 32'h0);
		$display("test reset_and_gpio done");
		// velocity over one tick window, aligned on the tick interrupt
		wr(OFS_INT_MASK, 32'h10);
		wr(OFS_INT_STS, 32'h1f);
		wait_irq();
		quad(AUX1_IDX, 4);
		wr(OFS_INT_STS, 32'h10);
		wait_irq();
		rd(OFS_AUX_VEL, 32'hffffffff, 32'h4);
		rd(OFS_AUX_POS, 32'hffffffff, 32'h4);
		wr(OFS_ENC_DIR, 32'h3f);
		rd(OFS_ENC_DIR, 32'hffffffff, 32'h3f);
		rd(OFS_AUX_POS, 32'hffffffff, 32'h4);
		quad(AUX1_IDX, 4);
		rd(OFS_AUX_POS, 32'hffffffff, 32'h0);
		wr(OFS_AUX_SEL, {30'h0, AUX_SEL_NO2});
		quad(AUX2_IDX, 2);
		rd(OFS_AUX_POS, 32'hffffffff, 32'hfffffffe);
		wr(OFS_AUX_SEL, 32'h3);
		rd(OFS_AUX_SEL, 32'h3, {30'h0, AUX_SEL_NO2});
		$display("test encoders done");
		wr(OFS_AUTO_COMMIT, 32'h2);
		wr(OFS_IRQ_SRC, 32'h1);
		wr(OFS_INT_MASK, 32'h0f);
		wr(OFS_INT_STS, 32'h1f);
		irq_is(1'b0);
		wr(OFS_BRK_ARM, 32'h2);
		rd(OFS_BRK_ARM, 32'hf, 32'h2);
		home_pulse();
		chk({28'h0, seen}, 32'h2);
		rd({OFS_AXIS_STS_PAGE, 4'h4}, 32'h3004, 32'h1004);
		rd(OFS_BRK_ARM, 32'hf, 32'h0);
		irq_is(1'b1);
		wr({OFS_AXIS_STS_PAGE, 4'h4}, 32'h4);
		wr(OFS_INT_STS, 32'h2);
		rd({OFS_AXIS_STS_PAGE, 4'h4}, 32'h4, 32'h0);
		home_pulse();
		chk({28'h0, seen}, 32'h0);
		rd(OFS_INT_STS, 32'hf, 32'h0);
		irq_is(1'b0);
		$display("test breakpoint done");
		@(posedge sys_clk_in);
		axis_event_in <= 32'h1;
		@(posedge sys_clk_in);
		axis_event_in <= 32'h0;
		rd({OFS_AXIS_STS_PAGE, 4'h0}, 32'h1, 32'h1);
		irq_is(1'b1);
		wr(OFS_IRQ_SRC, 32'h0);
		irq_is(1'b0);
		rd(8'hfc, 32'hffffffff, 32'h0);
		$display("test events done");
		finish_test();
	end
endmodule // testbench
`default_nettype wire
